// >>> gsd_defs.vh
// Purpose: shared constants for the guard supervisor and bus decode block
// Assumes: 250 MHz core clock, divider ratios given as clock counts
// Notes:   all figures are the documented values
`ifndef GSD_DEFS_VH
`define GSD_DEFS_VH
`define GSD_CLK_MHZ          250
`define GSD_BAUD_HZ          19200
`define GSD_WDOG_DIV         16384
`define GSD_WDOG_INTERVAL_MS 427
`define GSD_CPU_CLK_HZ       1228800
`define GSD_BREAK_DIV        16384
`define GSD_BREAK_US         6670
`define GSD_RESET_HOLD_MS    130
`define GSD_RESET_HOLD_CYC   (`GSD_RESET_HOLD_MS * `GSD_CLK_MHZ * 1000)
`define GSD_BAUD_HALF_CYC    (`GSD_CLK_MHZ * 1000000 / (2 * `GSD_BAUD_HZ))
`define GSD_PERIPH_BASE      16'h4000
`define GSD_PERIPH_MASK      16'hE000
`define GSD_ALIAS_TOP        16'h5FFF
`define GSD_BLOCK_LSB        3
`define GSD_BLOCK_MSB        6
`define GSD_INTREG_TOP       16'h0027
`define GSD_NSEL             16
`endif

// >>> gsd_host_model.sv
// Purpose: remote host end of the receive line
// Assumes: no framed traffic, idle or break only
// Notes: line is high when idle
`timescale 1ns/1ns
module gsd_host_model (
    input  wire  mclk_i,
    input  wire  brk_i,
    output logic serial_receive_o
);
    initial serial_receive_o = 1'b1;
    // line follows the request just after the rising edge, never racing the bench
    always @(posedge mclk_i) serial_receive_o <= ~brk_i;
endmodule // gsd_host_model

// >>> gsd_supervisor.v
// Purpose: watchdog, break detect, reset stretch and guarded bus decode
// Assumes: cpu phase clock and receive line are synchronous levels
// Notes:   long counts are parameters so simulation can shorten them
//          divider ratios must be even: each output period splits in halves
//          a clear beats a timeout that lands in the same cycle
//
// Summary of operation
// - free-running watchdog clock at baud rate
// - watchdog divides its clock by fixed ratio
// - timeout asserts analog reset and nmi
// - analog reset also at power-up, board reset
// - analog access or clear toggle restarts watchdog
// - clear line low disables the watchdog
// - fail, button or break stretch board reset
// - break counter divides cpu clock fixed ratio
// - receive high holds break counter cleared
// - serial baud equals watchdog clock frequency
// - address bits three to six decode selects
// - eight-byte blocks, upper range aliases window
// - internal registers sit at lowest addresses
// - disabled bus forces inactive control lines
// - bidirectional eight-bit data buffer to bus
// - converter interrupt inverted toward processor
`timescale 1ns/1ns
`include "gsd_defs.vh"
module gsd_supervisor #(
    parameter WDOG_DIV       = `GSD_WDOG_DIV,
    parameter BREAK_DIV      = `GSD_BREAK_DIV,
    parameter RESET_HOLD_CYC = `GSD_RESET_HOLD_CYC,
    parameter BAUD_HALF_CYC  = `GSD_BAUD_HALF_CYC
) (
    input  wire        mclk_i,
    input  wire        rstn_i,
    input  wire        ce_i,
    input  wire        cpu_phase_clock_i,
    input  wire        serial_receive_i,
    input  wire        serial_transmit_i,
    input  wire        power_fail_i,
    input  wire        button_reset_i,
    input  wire        watchdog_clear_n_i,
    input  wire [15:0] cpu_addr_i,
    input  wire        cpu_rd_i,
    input  wire        cpu_wr_i,
    input  wire [7:0]  cpu_data_i,
    input  wire        guarded_bus_enable_n_i,
    input  wire [7:0]  bus_data_i,
    input  wire        converter_int_i,
    output reg         baud_clock_o,
    output wire        watchdog_divider_output_o,
    output wire        analog_reset_o,
    output wire        watchdog_nmi_n_o,
    output wire        board_reset_n_o,
    output wire        break_detect_o,
    output wire        serial_transmit_o,
    output wire [15:0] assembly_select_n_o,
    output wire        internal_reg_sel_o,
    output reg  [15:0] bus_addr_o,
    output reg         bus_rd_n_o,
    output reg         bus_wr_n_o,
    output reg  [7:0]  bus_data_o,
    output reg         bus_data_oe_o,
    output reg  [7:0]  cpu_data_o,
    output reg         cpu_irq_n_o
);
    localparam [31:0] BAUD_LAST      = BAUD_HALF_CYC - 1;
    localparam [14:0] WDOG_LAST      = WDOG_DIV - 1;
    localparam [14:0] WDOG_HALF      = WDOG_DIV / 2;
    localparam [14:0] WDOG_HALF_LAST = (WDOG_DIV / 2) - 1;
    localparam [14:0] BRK_HALF_LAST  = (BREAK_DIV / 2) - 1;
    localparam [31:0] HOLD_LOAD      = RESET_HOLD_CYC;

    // baud divider state
    reg  [31:0] baud_cnt;
    reg  [31:0] next_baud_cnt;
    reg         next_baud_clock;

    // watchdog state
    reg  [14:0] wdog_cnt;
    reg  [14:0] next_wdog_cnt;
    reg         wdog_out_q;
    reg         next_wdog_out;
    reg         timeout;
    reg         next_timeout;

    // edge detector state
    reg         baud_q;
    reg         clr_q;
    reg         phase_q;

    // break detector state
    reg  [14:0] brk_cnt;
    reg  [14:0] next_brk_cnt;
    reg         brk_out;
    reg         next_brk_out;

    // reset stretcher state
    reg  [31:0] hold_cnt;
    reg  [31:0] next_hold_cnt;
    reg         pup_done;

    // guarded bus next values
    reg  [15:0] next_bus_addr;
    reg         next_bus_rd_n;
    reg         next_bus_wr_n;
    reg         next_bus_data_oe;
    reg  [7:0]  next_bus_data;
    reg  [7:0]  next_cpu_data;

    wire        periph_hit;
    wire        cpu_access;
    wire        analog_access;
    wire        clr_toggle;
    wire        wdog_clear;
    wire        baud_rise;
    wire        phase_rise;
    wire        reset_req;
    wire        stretch_busy;
    wire        bus_live;
    wire [3:0]  block_sel;

    // baud divider: free-running once out of reset, no software upkeep
    always @* begin
        next_baud_cnt   = baud_cnt + 32'h0000_0001;
        next_baud_clock = baud_clock_o;
        if (baud_cnt >= BAUD_LAST) begin
            next_baud_cnt   = 32'h0000_0000;
            next_baud_clock = ~baud_clock_o;
        end
    end

    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            baud_cnt     <= 32'h0000_0000;
            baud_clock_o <= 1'b0;
        end else if (ce_i) begin
            baud_cnt     <= next_baud_cnt;
            baud_clock_o <= next_baud_clock;
        end
    end

    assign serial_transmit_o = serial_transmit_i;

    // edge detectors reset to the idle level of their source, so no false
    // edge follows reset
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            baud_q  <= 1'b0;
            clr_q   <= 1'b1;
            phase_q <= 1'b0;
        end else if (ce_i) begin
            baud_q  <= baud_clock_o;
            clr_q   <= watchdog_clear_n_i;
            phase_q <= cpu_phase_clock_i;
        end
    end

    assign baud_rise  = baud_clock_o & ~baud_q;
    assign phase_rise = cpu_phase_clock_i & ~phase_q;
    assign clr_toggle = watchdog_clear_n_i ^ clr_q;

    // address decode: 0x4000-0x5FFF folds onto the 128-byte window
    assign periph_hit    = (cpu_addr_i & `GSD_PERIPH_MASK) == `GSD_PERIPH_BASE;
    assign block_sel     = cpu_addr_i[`GSD_BLOCK_MSB:`GSD_BLOCK_LSB];
    assign cpu_access    = cpu_rd_i | cpu_wr_i;
    assign analog_access = periph_hit & cpu_access;
    assign wdog_clear    = analog_access | clr_toggle;
    assign bus_live      = ~guarded_bus_enable_n_i;
    assign internal_reg_sel_o = cpu_addr_i <= `GSD_INTREG_TOP;

    genvar g;
    generate
        for (g = 0; g < `GSD_NSEL; g = g + 1) begin : g_sel
            assign assembly_select_n_o[g] = ~(periph_hit & bus_live & (block_sel == g));
        end
    endgenerate

    // watchdog: output low one interval then high; reaching the rise with no
    // clear latches the timeout until the next clear
    always @* begin
        next_wdog_cnt = wdog_cnt;
        next_timeout  = timeout;
        next_wdog_out = wdog_cnt >= WDOG_HALF;
        if (!watchdog_clear_n_i) begin
            next_wdog_cnt = 15'h0000;
            next_timeout  = 1'b0;
        end else if (wdog_clear) begin
            next_wdog_cnt = 15'h0000;
            next_timeout  = 1'b0;
        end else if (baud_rise) begin
            if (wdog_cnt == WDOG_LAST) begin
                next_wdog_cnt = 15'h0000;
            end else begin
                next_wdog_cnt = wdog_cnt + 15'h0001;
            end
            if (wdog_cnt == WDOG_HALF_LAST) begin
                next_timeout = 1'b1;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            wdog_cnt   <= 15'h0000;
            wdog_out_q <= 1'b0;
            timeout    <= 1'b0;
        end else if (ce_i) begin
            wdog_cnt   <= next_wdog_cnt;
            wdog_out_q <= next_wdog_out;
            timeout    <= next_timeout;
        end
    end

    assign watchdog_divider_output_o = wdog_out_q;
    assign watchdog_nmi_n_o          = ~timeout;

    // break detector: counts cpu phase clock rises only while receive is low
    always @* begin
        next_brk_cnt = brk_cnt;
        next_brk_out = brk_out;
        if (serial_receive_i) begin
            next_brk_cnt = 15'h0000;
            next_brk_out = 1'b0;
        end else if (phase_rise) begin
            if (brk_cnt == BRK_HALF_LAST) begin
                next_brk_cnt = 15'h0000;
                next_brk_out = ~brk_out;
            end else begin
                next_brk_cnt = brk_cnt + 15'h0001;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            brk_cnt <= 15'h0000;
            brk_out <= 1'b0;
        end else if (ce_i) begin
            brk_cnt <= next_brk_cnt;
            brk_out <= next_brk_out;
        end
    end

    assign break_detect_o = brk_out;

    // reset stretcher: a new event during the hold restarts the full stretch,
    // so a held break keeps the board in reset
    assign reset_req    = power_fail_i | button_reset_i | brk_out;
    assign stretch_busy = hold_cnt != 32'h0000_0000;

    always @* begin
        next_hold_cnt = hold_cnt;
        if (reset_req || !pup_done) begin
            next_hold_cnt = HOLD_LOAD;
        end else if (stretch_busy) begin
            next_hold_cnt = hold_cnt - 32'h0000_0001;
        end
    end

    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            hold_cnt <= 32'h0000_0000;
            pup_done <= 1'b0;
        end else if (ce_i) begin
            hold_cnt <= next_hold_cnt;
            pup_done <= 1'b1;
        end
    end

    assign board_reset_n_o = pup_done & ~stretch_busy;
    assign analog_reset_o  = timeout | ~board_reset_n_o | ~rstn_i;

    // guarded bus buffer: a disabled bus parks address and strobes inactive;
    // data registers keep their last value since nothing is driven then
    always @* begin
        next_bus_addr    = 16'h0000;
        next_bus_rd_n    = 1'b1;
        next_bus_wr_n    = 1'b1;
        next_bus_data_oe = 1'b0;
        next_bus_data    = bus_data_o;
        next_cpu_data    = cpu_data_o;
        if (bus_live) begin
            next_bus_addr    = cpu_addr_i;
            next_bus_rd_n    = ~cpu_rd_i;
            next_bus_wr_n    = ~cpu_wr_i;
            next_bus_data_oe = cpu_wr_i;
            next_bus_data    = cpu_data_i;
            next_cpu_data    = bus_data_i;
        end
    end

    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            bus_addr_o    <= 16'h0000;
            bus_rd_n_o    <= 1'b1;
            bus_wr_n_o    <= 1'b1;
            bus_data_oe_o <= 1'b0;
        end else if (ce_i) begin
            bus_addr_o    <= next_bus_addr;
            bus_rd_n_o    <= next_bus_rd_n;
            bus_wr_n_o    <= next_bus_wr_n;
            bus_data_oe_o <= next_bus_data_oe;
        end
    end

    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            bus_data_o <= 8'h00;
            cpu_data_o <= 8'h00;
        end else if (ce_i) begin
            bus_data_o <= next_bus_data;
            cpu_data_o <= next_cpu_data;
        end
    end

    // converter interrupt is active high, the processor input wants it low
    always @(posedge mclk_i) begin
        if (!rstn_i) begin
            cpu_irq_n_o <= 1'b1;
        end else if (ce_i) begin
            cpu_irq_n_o <= ~converter_int_i;
        end
    end
endmodule // gsd_supervisor

// >>> gsd_supervisor_checker.sv
// Purpose: port-level checks of the supervisor
// Assumes: inputs change away from the rising edge
// Notes: bound to every supervisor instance
`timescale 1ns/1ns
module gsd_supervisor_checker (
    input wire        mclk_i, rstn_i, ce_i, serial_receive_i, watchdog_clear_n_i, cpu_rd_i,
    input wire        guarded_bus_enable_n_i, converter_int_i, analog_reset_o,
    input wire        watchdog_nmi_n_o, board_reset_n_o, break_detect_o, internal_reg_sel_o,
    input wire        bus_rd_n_o, bus_wr_n_o, bus_data_oe_o, cpu_irq_n_o,
    input wire [15:0] cpu_addr_i, assembly_select_n_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    property p_nmi; !watchdog_nmi_n_o |-> analog_reset_o; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi without analog reset");
    property p_rst; !board_reset_n_o |-> analog_reset_o; endproperty
    a_rst: assert property (p_rst) else $error("board reset without analog reset");
    property p_clr; ce_i && cpu_rd_i && cpu_addr_i[15:13] == 3'h2 |=> watchdog_nmi_n_o; endproperty
    a_clr: assert property (p_clr) else $error("analog access left nmi");
    property p_dis; ce_i && !watchdog_clear_n_i |=> watchdog_nmi_n_o; endproperty
    a_dis: assert property (p_dis) else $error("nmi while disabled");
    property p_idle; ce_i && serial_receive_i |=> !break_detect_o; endproperty
    a_idle: assert property (p_idle) else $error("break while line idle");
    property p_brk; break_detect_o |-> ##[0:2] !board_reset_n_o; endproperty
    a_brk: assert property (p_brk) else $error("break gave no board reset");
    property p_off; guarded_bus_enable_n_i |-> assembly_select_n_o == 16'hFFFF; endproperty
    a_off: assert property (p_off) else $error("select on disabled bus");
    property p_dec; !guarded_bus_enable_n_i && cpu_addr_i[15:13] == 3'h2
        |-> assembly_select_n_o == ~(16'h0001 << cpu_addr_i[6:3]); endproperty
    a_dec: assert property (p_dec) else $error("wrong select");
    property p_ctl; ce_i && guarded_bus_enable_n_i
        |=> bus_rd_n_o && bus_wr_n_o && !bus_data_oe_o; endproperty
    a_ctl: assert property (p_ctl) else $error("control active on disabled bus");
    property p_irq; ce_i |=> cpu_irq_n_o == !$past(converter_int_i); endproperty
    a_irq: assert property (p_irq) else $error("irq not inverted");
    property p_int; internal_reg_sel_o == (cpu_addr_i <= 16'h0027); endproperty
    a_int: assert property (p_int) else $error("internal select wrong");
endmodule // gsd_supervisor_checker
bind gsd_supervisor gsd_supervisor_checker u_gsd_supervisor_checker (.*);

// >>> gsd_supervisor_test.sv
// Purpose: self-checking bench for the supervisor
// Assumes: shortened counts 16/16/20/4
// Notes: ce_i dropped once to check the freeze
`timescale 1ns/1ns
module gsd_supervisor_test;
    logic mclk_i = 0, rstn_i = 0, ce_i = 1, cpu_phase_clock_i = 0, serial_transmit_i = 1;
    logic power_fail_i = 0, button_reset_i = 0, watchdog_clear_n_i = 1, cpu_rd_i = 0;
    logic cpu_wr_i = 0, guarded_bus_enable_n_i = 0, converter_int_i = 0, brk = 0;
    logic [15:0] cpu_addr_i = 16'h0000;
    logic [7:0]  cpu_data_i = 8'h00, bus_data_i = 8'h00;
    wire serial_receive_i, baud_clock_o, watchdog_divider_output_o, analog_reset_o;
    wire watchdog_nmi_n_o, board_reset_n_o, break_detect_o, serial_transmit_o;
    wire internal_reg_sel_o, bus_rd_n_o, bus_wr_n_o, bus_data_oe_o, cpu_irq_n_o;
    wire [15:0] assembly_select_n_o, bus_addr_o;
    wire [7:0]  bus_data_o, cpu_data_o;
    int failures = 0, compares = 0;
    gsd_supervisor #(.WDOG_DIV(16), .BREAK_DIV(16), .RESET_HOLD_CYC(20), .BAUD_HALF_CYC(4))
        u_gsd_supervisor (.*);
    gsd_host_model u_gsd_host_model (.mclk_i(mclk_i), .brk_i(brk),
        .serial_receive_o(serial_receive_i));
    always #2 mclk_i = ~mclk_i;
    always @(negedge mclk_i) cpu_phase_clock_i <= ~cpu_phase_clock_i;
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task run(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task t_reset;
        cmp(board_reset_n_o, 1'b0);
        run(25);
        cmp(board_reset_n_o, 1'b1);
        cmp(analog_reset_o, 1'b0);
    endtask
    task t_wdog;
        watchdog_clear_n_i = 0; run(1); watchdog_clear_n_i = 1;
        run(40);
        cmp(watchdog_nmi_n_o, 1'b1);
        cmp(watchdog_divider_output_o, 1'b0);
        run(60);
        cmp(watchdog_nmi_n_o, 1'b0);
        cmp(watchdog_divider_output_o, 1'b1);
        cmp(analog_reset_o, 1'b1);
        cpu_addr_i = 16'h4008; cpu_rd_i = 1; run(1); cpu_rd_i = 0; run(1);
        cmp(watchdog_nmi_n_o, 1'b1);
        watchdog_clear_n_i = 0; run(120);
        cmp(watchdog_nmi_n_o, 1'b1);
        watchdog_clear_n_i = 1;
    endtask
    task t_break;
        brk = 1; run(24);
        cmp(break_detect_o, 1'b1);
        cmp(board_reset_n_o, 1'b0);
        brk = 0; run(2);
        cmp(break_detect_o, 1'b0);
        run(25);
        cmp(board_reset_n_o, 1'b1);
        for (int i = 0; i < 2; i++) begin
            {power_fail_i, button_reset_i} = i ? 2'b01 : 2'b10; run(1);
            {power_fail_i, button_reset_i} = 2'b00; run(2);
            cmp(board_reset_n_o, 1'b0);
            run(25);
            cmp(board_reset_n_o, 1'b1);
        end
    endtask
    task t_bus;
        // odd blocks use the alias range so both windows are seen
        for (int i = 0; i < 16; i++) begin
            cpu_addr_i = 16'h4000 + 16'(i * 8) + (i[0] ? 16'h0080 : 16'h0000);
            run(1);
            cmp(assembly_select_n_o, ~(16'h0001 << i));
        end
        guarded_bus_enable_n_i = 1; cpu_rd_i = 1; run(1);
        cmp(assembly_select_n_o, 16'hFFFF);
        cmp({bus_rd_n_o, bus_wr_n_o}, 16'h0003);
        guarded_bus_enable_n_i = 0; cpu_rd_i = 0; cpu_wr_i = 1; cpu_data_i = 8'hA5;
        cpu_addr_i = 16'h4010; run(1);
        cmp({bus_data_oe_o, bus_wr_n_o, bus_data_o}, 16'h02A5);
        cmp(bus_addr_o, 16'h4010);
        cpu_wr_i = 0; cpu_rd_i = 1; bus_data_i = 8'h3C; run(1);
        cmp({bus_rd_n_o, cpu_data_o}, 16'h003C);
        cpu_rd_i = 0; converter_int_i = 1; run(1);
        cmp(cpu_irq_n_o, 1'b0);
        cpu_addr_i = 16'h0027;
        run(1);
        cmp(internal_reg_sel_o, 1'b1);
        cpu_addr_i = 16'h0028;
        serial_transmit_i = 0;
        run(1);
        cmp(internal_reg_sel_o, 1'b0);
        cmp(serial_transmit_o, 1'b0);
    endtask
    task t_baud;
        logic [15:0] hi;
        logic [15:0] lo;
        logic        held;
        hi = 16'h0000;
        lo = 16'h0000;
        while (baud_clock_o !== 1'b0) run(1);
        while (baud_clock_o !== 1'b1) run(1);
        while (baud_clock_o === 1'b1 && hi < 16'h0009) begin
            hi++;
            run(1);
        end
        while (baud_clock_o === 1'b0 && lo < 16'h0009) begin
            lo++;
            run(1);
        end
        cmp(hi, 16'h0004);
        cmp(lo, 16'h0004);
        ce_i = 1'b0;
        held = baud_clock_o;
        run(12);
        cmp(baud_clock_o, held);
        ce_i = 1'b1;
    endtask
    task complete_run;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        failures++;
        complete_run;
    end
    initial begin
        run(3); rstn_i = 1; run(1);
        t_reset; t_wdog; t_break; t_bus; t_baud;
        complete_run;
    end
endmodule // gsd_supervisor_test
